// ==== tlb_test_pkg.sv ====
// shared constants, register layouts and types for the buffer test access block
`default_nettype none

package tlb_test_pkg;

  // register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_COMMAND      = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_PAYLOAD      = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_MACHINE_CTRL = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_PAGE_DIR     = 4'hc;

  // buffer geometry
  localparam int WAYS    = 4;
  localparam int WAY_W   = 2;
  localparam int TAG_W   = 20;
  localparam int PHYS_W  = 20;

  // field positions
  localparam int PAGING_BIT   = 31;
  localparam int PAGE_DIR_LSB = 12;

  // reset values
  localparam logic [DATA_W-1:0] COMMAND_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] PAYLOAD_RESET = 32'h0000_0000;
  localparam logic [TAG_W-1:0]  PAGE_DIR_RESET = 20'h0_0000;
  localparam logic              PAGING_RESET  = 1'b0;
  localparam logic [WAY_W-1:0]  POINTER_RESET = 2'h0;

  // command bit encoding
  typedef enum logic
  {
    CMD_ENTRY_WRITE = 1'b0,
    CMD_LOOKUP      = 1'b1
  } tlb_cmd_t;

  // command register layout, bit 31 down to bit 0
  typedef struct packed
  {
    logic [TAG_W-1:0] linear_tag;
    logic             valid;
    logic             dirty_t;
    logic             dirty_c;
    logic             user_t;
    logic             user_c;
    logic             writable_t;
    logic             writable_c;
    logic [3:0]       rsvd;
    tlb_cmd_t         cmd;
  } command_t;

  // data register layout, bit 31 down to bit 0
  typedef struct packed
  {
    logic [PHYS_W-1:0] phys;
    logic [6:0]        rsvd_hi;
    logic              hit_or_placement_flag;
    logic [WAY_W-1:0]  block_selector;
    logic [1:0]        rsvd_lo;
  } payload_t;

  // one buffer entry
  typedef struct packed
  {
    logic              valid;
    logic [TAG_W-1:0]  tag;
    logic              dirty;
    logic              user;
    logic              writable;
    logic [PHYS_W-1:0] phys;
  } entry_t;

endpackage

`default_nettype wire

// ==== tlb_test_access.sv ====
// test access port into the paging translation look-aside buffer
//
// Function
// [RULE1] software keeps paging off while using the test registers
// [RULE2] command register write starts entry write (0) or lookup (1)
// [RULE3] entry write allocates entry tagged by linear address, filled from both registers
// [RULE4] lookup loads remaining fields only when exactly one entry matches
// [RULE5] physical address stored on write, returned on lookup hit
// [RULE6] placement flag 1 selects block by selector, 0 uses internal pointer
// [RULE7] lookup sets hit flag 1 on hit, 0 on miss
// [RULE8] valid bit written or read back; page directory write clears all valids
// [RULE9] dirty, user, writable each carried as true/complement pair
// [RULE10] pair 00 misses all, 01 matches 0, 10 matches 1, 11 matches all
// [RULE11] software loads data register before writing command with bit 0
// [RULE12] software writes command with bit 1, then reads both registers
// [RULE13] on miss other fields are indeterminate; trust them only on hit
// [RULE14] command: tag 31:12, valid 11, three pairs 10:5, command bit 0
// [RULE15] data: physical 31:12, low bits hold hit/placement flag and selector
// [RULE16] software writes zero to reserved bits and ignores them
// [RULE17] without an operation, each register reads back its last written value
// [RULE18] lookup matching several entries counts as miss, no field updated
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`default_nettype none

module tlb_test_access
  import tlb_test_pkg::*;
#(
  parameter int SET_BITS = 3
)
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output var  logic [DATA_W-1:0] rd_data
);

  localparam int SETS = 1 << SET_BITS;

  // storage and software-visible state
  entry_t              tlb [WAYS][SETS];
  command_t            command;
  payload_t            payload;
  logic                paging_on;
  logic [TAG_W-1:0]    page_dir_base;
  logic [WAY_W-1:0]    place_ptr;

  // decode and operation signals
  command_t            wr_cmd;
  payload_t            wr_payload;
  logic                cmd_sel;
  logic                payload_sel;
  logic                ctrl_sel;
  logic                page_dir_sel;
  logic                write_go;
  logic                lookup_go;
  logic [SET_BITS-1:0] op_set;
  logic [WAYS-1:0]     way_match;
  logic                hit_one;
  logic [WAY_W-1:0]    hit_way;
  entry_t              hit_entry;
  logic [WAY_W-1:0]    wr_way;
  entry_t              new_entry;
  command_t            next_command;

  // set index taken from the low tag bits
  function automatic logic [SET_BITS-1:0] set_of(input logic [TAG_W-1:0] tag);
    set_of = tag[SET_BITS-1:0];
  endfunction

  // true/complement pair acts as match-if-1, match-if-0, both or neither
  function automatic logic attr_match(input logic t, input logic c, input logic x);
    attr_match = (t & x) | (c & ~x);
  endfunction

  // register bus decode
  assign wr_cmd       = command_t'(wr_data);
  assign wr_payload   = payload_t'(wr_data);
  assign cmd_sel      = wr_en && (addr == OFS_COMMAND);
  assign payload_sel  = wr_en && (addr == OFS_PAYLOAD);
  assign ctrl_sel     = wr_en && (addr == OFS_MACHINE_CTRL);
  assign page_dir_sel = wr_en && (addr == OFS_PAGE_DIR);

  // operations fire in the write cycle itself; gated off while paging runs
  assign write_go  = cmd_sel && !paging_on && (wr_cmd.cmd == CMD_ENTRY_WRITE); // [RULE2] [RULE1]
  assign lookup_go = cmd_sel && !paging_on && (wr_cmd.cmd == CMD_LOOKUP);      // [RULE2] [RULE1]
  assign op_set    = set_of(wr_cmd.linear_tag);

  // per-way compare of tag, valid bit and the three attribute pairs
  generate
    for (genvar g = 0; g < WAYS; g++)
    begin : g_match
      assign way_match[g] = tlb[g][op_set].valid == wr_cmd.valid &&
                            tlb[g][op_set].tag == wr_cmd.linear_tag &&
                            attr_match(wr_cmd.dirty_t, wr_cmd.dirty_c,
                                       tlb[g][op_set].dirty) &&       // [RULE10]
                            attr_match(wr_cmd.user_t, wr_cmd.user_c,
                                       tlb[g][op_set].user) &&        // [RULE10]
                            attr_match(wr_cmd.writable_t, wr_cmd.writable_c,
                                       tlb[g][op_set].writable);      // [RULE10]
    end
  endgenerate

  // exactly one match is a hit; several matches count as a miss
  assign hit_one = $onehot(way_match); // [RULE4] [RULE18]

  // encode the matching way
  always_comb
  begin
    hit_way = '0;
    for (int w = 0; w < WAYS; w++)
    begin
      if (way_match[w])
      begin
        hit_way = WAY_W'(w);
      end
    end
  end

  assign hit_entry = tlb[hit_way][op_set];

  // placement: selector when flag set, else the internal pointer
  assign wr_way = payload.hit_or_placement_flag ? payload.block_selector : place_ptr; // [RULE6]

  // new entry built from the data register and the value being written
  always_comb
  begin
    new_entry          = '0;
    new_entry.valid    = wr_cmd.valid;          // [RULE8]
    new_entry.tag      = wr_cmd.linear_tag;     // [RULE3]
    new_entry.dirty    = wr_cmd.dirty_t;        // [RULE9]
    new_entry.user     = wr_cmd.user_t;         // [RULE9]
    new_entry.writable = wr_cmd.writable_t;     // [RULE9]
    new_entry.phys     = payload.phys;          // [RULE5]
  end

  // buffer storage; a page directory write flushes every valid bit
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int w = 0; w < WAYS; w++)
      begin
        for (int s = 0; s < SETS; s++)
        begin
          tlb[w][s] <= '0;
        end
      end
    end
    else if (page_dir_sel)
    begin
      for (int w = 0; w < WAYS; w++)
      begin
        for (int s = 0; s < SETS; s++)
        begin
          tlb[w][s].valid <= 1'b0; // [RULE8]
        end
      end
    end
    else if (write_go)
    begin
      tlb[wr_way][op_set] <= new_entry; // [RULE3]
    end
  end

  // round-robin pointer advances only when it chose the block
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      place_ptr <= POINTER_RESET;
    end
    else if (write_go && !payload.hit_or_placement_flag)
    begin
      place_ptr <= place_ptr + 2'h1; // [RULE6]
    end
  end

  // command value stored: reserved bits dropped, attributes from a hit
  always_comb
  begin
    next_command      = wr_cmd;
    next_command.rsvd = '0; // [RULE14]
    if (lookup_go && hit_one)
    begin
      next_command.valid      = hit_entry.valid;     // [RULE8]
      next_command.dirty_t    = hit_entry.dirty;     // [RULE9]
      next_command.dirty_c    = ~hit_entry.dirty;    // [RULE9]
      next_command.user_t     = hit_entry.user;      // [RULE9]
      next_command.user_c     = ~hit_entry.user;     // [RULE9]
      next_command.writable_t = hit_entry.writable;  // [RULE9]
      next_command.writable_c = ~hit_entry.writable; // [RULE9]
    end
  end

  // command register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      command <= command_t'(COMMAND_RESET);
    end
    else if (cmd_sel)
    begin
      command <= next_command; // [RULE17] [RULE4]
    end
  end

  // data register; a lookup rewrites it, a miss touches only the flag
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      payload <= payload_t'(PAYLOAD_RESET);
    end
    else if (payload_sel)
    begin
      payload         <= wr_payload; // [RULE17] [RULE15]
      payload.rsvd_hi <= '0;
      payload.rsvd_lo <= '0;
    end
    else if (lookup_go)
    begin
      payload.hit_or_placement_flag <= hit_one; // [RULE7] [RULE18] [RULE13]
      if (hit_one)
      begin
        payload.phys           <= hit_entry.phys; // [RULE5]
        payload.block_selector <= hit_way;        // [RULE4]
      end
    end
  end

  // paging control bit and page directory base
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      paging_on     <= PAGING_RESET;
      page_dir_base <= PAGE_DIR_RESET;
    end
    else
    begin
      if (ctrl_sel)
      begin
        paging_on <= wr_data[PAGING_BIT];
      end
      if (page_dir_sel)
      begin
        page_dir_base <= wr_data[DATA_W-1:PAGE_DIR_LSB];
      end
    end
  end

  // read data for one cycle after the strobe, zero otherwise and when unmapped
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rd_data <= '0;
    end
    else if (rd_en)
    begin
      unique case (addr)
        OFS_COMMAND:      rd_data <= command;                            // [RULE17]
        OFS_PAYLOAD:      rd_data <= payload;                            // [RULE17]
        OFS_MACHINE_CTRL: rd_data <= {paging_on, 31'h0};
        OFS_PAGE_DIR:     rd_data <= {page_dir_base, 12'h000};
        default:          rd_data <= '0;
      endcase
    end
    else
    begin
      rd_data <= '0;
    end
  end

  // helper state for the checks below
  logic [WAY_W-1:0]    chk_way;
  logic [SET_BITS-1:0] chk_set;
  entry_t              chk_entry;
  logic                any_valid;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      chk_way <= '0;
      chk_set <= '0;
    end
    else if (write_go)
    begin
      chk_way <= wr_way;
      chk_set <= op_set;
    end
  end

  assign chk_entry = tlb[chk_way][chk_set];

  always_comb
  begin
    any_valid = 1'b0;
    for (int w = 0; w < WAYS; w++)
    begin
      for (int s = 0; s < SETS; s++)
      begin
        any_valid = any_valid | tlb[w][s].valid;
      end
    end
  end

  a_hit_flag_set: assert property (@(posedge clk_sys) disable iff (rst) // [RULE7]
    lookup_go && hit_one |=> payload.hit_or_placement_flag)
    else $error("lookup hit did not set the hit flag");

  a_miss_keeps_fields: assert property (@(posedge clk_sys) disable iff (rst) // [RULE18]
    lookup_go && !hit_one |=> !payload.hit_or_placement_flag &&
                              $stable(payload.phys) && $stable(payload.block_selector))
    else $error("lookup miss changed data fields or left hit flag set");

  a_hit_returns_phys: assert property (@(posedge clk_sys) disable iff (rst) // [RULE5]
    lookup_go && hit_one |=> payload.phys == $past(hit_entry.phys) &&
                             payload.block_selector == $past(hit_way))
    else $error("lookup hit returned wrong physical address or block");

  a_write_fills_entry: assert property (@(posedge clk_sys) disable iff (rst) // [RULE3]
    write_go |=> chk_entry.tag == $past(wr_cmd.linear_tag) &&
                 chk_entry.phys == payload.phys &&
                 chk_entry.valid == $past(wr_cmd.valid) &&
                 chk_entry.dirty == $past(wr_cmd.dirty_t))
    else $error("entry write stored wrong contents");

  a_placement_select: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
    write_go && payload.hit_or_placement_flag |-> wr_way == payload.block_selector)
    else $error("placed write went to the wrong block");

  a_pointer_advance: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
    write_go && !payload.hit_or_placement_flag |=> place_ptr == $past(place_ptr) + 2'h1)
    else $error("internal pointer did not advance after unplaced write");

  a_flush_all_valid: assert property (@(posedge clk_sys) disable iff (rst) // [RULE8]
    page_dir_sel |=> !any_valid)
    else $error("page directory write left a valid entry");

  a_paging_blocks_op: assert property (@(posedge clk_sys) disable iff (rst) // [RULE1]
    cmd_sel && paging_on |=> $stable(payload) && $stable(place_ptr))
    else $error("buffer operation ran while paging was on");

  a_readback_command: assert property (@(posedge clk_sys) disable iff (rst) // [RULE17]
    rd_en && addr == OFS_COMMAND |=> rd_data == $past(command))
    else $error("command register read back wrong value");

  a_hit_attr_pair: assert property (@(posedge clk_sys) disable iff (rst) // [RULE9]
    lookup_go && hit_one |=> command.dirty_t == ~command.dirty_c &&
                             command.user_t == ~command.user_c &&
                             command.writable_t == ~command.writable_c)
    else $error("lookup hit reported an inconsistent attribute pair");

  c_lookup_hit: cover property (@(posedge clk_sys) disable iff (rst)
    write_go ##[1:4] lookup_go && hit_one);

  c_lookup_multi: cover property (@(posedge clk_sys) disable iff (rst)
    lookup_go && way_match != '0 && !hit_one);

  c_placed_write: cover property (@(posedge clk_sys) disable iff (rst)
    write_go && payload.hit_or_placement_flag);

  c_flush_then_miss: cover property (@(posedge clk_sys) disable iff (rst)
    page_dir_sel ##[1:8] lookup_go && !hit_one);

endmodule

`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the buffer test access block
`default_nettype none

module tb_top
  import tlb_test_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_sys = 1'b0;
  logic              rst     = 1'b1;
  logic [ADDR_W-1:0] addr    = 4'h0;
  logic [DATA_W-1:0] wr_data = 32'h0;
  logic              wr_en   = 1'b0;
  logic              rd_en   = 1'b0;
  logic [DATA_W-1:0] rd_data;
  int                mismatches = 0;
  int                cmp_count  = 0;

  // 100 MHz core clock
  always #5 clk_sys = ~clk_sys;

  tlb_test_access #(
    .SET_BITS (3)
  ) dut (
    .clk_sys (clk_sys),
    .rst     (rst),
    .addr    (addr),
    .wr_data (wr_data),
    .wr_en   (wr_en),
    .rd_en   (rd_en),
    .rd_data (rd_data)
  );

  // command word: tag, valid, three true/complement pairs, reserved zero, command bit
  function automatic logic [DATA_W-1:0] cmdv(input logic [TAG_W-1:0] tag, input logic v,
                                             input logic [1:0] d2, input logic [1:0] u2,
                                             input logic [1:0] w2, input logic c);
    return {tag, v, d2, u2, w2, 4'h0, c};
  endfunction

  // payload word: physical page, flag, block selector, reserved zero
  function automatic logic [DATA_W-1:0] pay(input logic [PHYS_W-1:0] phys, input logic f,
                                            input logic [WAY_W-1:0] sel);
    return {phys, 7'h00, f, sel, 2'h0};
  endfunction

  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe; dropping it costs a cycle so strobes never collide
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
  endtask

  // read data is looked at in the one cycle it stands, then must fall back to zero
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
    @(posedge clk_sys);
    #1;
    chk(rd_data, 32'h0);
  endtask

  // lookup then read both registers back, as software does
  task automatic look(input logic [DATA_W-1:0] c, input logic [DATA_W-1:0] ep,
                      input logic [DATA_W-1:0] ec);
    wr(OFS_COMMAND, c);
    rd(OFS_PAYLOAD, ep);
    rd(OFS_COMMAND, ec);
  endtask

  // hang guard, far beyond the fewer than two hundred cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    finish_test();
  end

  // main sequence
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFS_COMMAND, COMMAND_RESET);
    rd(OFS_PAYLOAD, PAYLOAD_RESET);
    rd(OFS_MACHINE_CTRL, 32'h0);
    rd(OFS_PAGE_DIR, 32'h0);
    wr(4'h1, 32'hffff_ffff);
    rd(4'h1, 32'h0);
    // the data register reads back as written; software keeps reserved bits at zero
    wr(OFS_PAYLOAD, 32'h1234_501c);
    rd(OFS_PAYLOAD, 32'h1234_501c);
    // placed entry write into block 2, payload overwritten before the lookup
    wr(OFS_PAYLOAD, pay(20'habcde, 1'b1, 2'h2));
    wr(OFS_COMMAND, cmdv(20'h11111, 1'b1, 2'b10, 2'b01, 2'b10, 1'b0));
    wr(OFS_PAYLOAD, 32'h0);
    look(cmdv(20'h11111, 1'b1, 2'b11, 2'b11, 2'b11, 1'b1), pay(20'habcde, 1'b1, 2'h2),
         cmdv(20'h11111, 1'b1, 2'b10, 2'b01, 2'b10, 1'b1));
    // every dirty pair code against a stored dirty bit of 1
    for (int i = 0; i < 4; i++)
      look(cmdv(20'h11111, 1'b1, i[1:0], 2'b11, 2'b11, 1'b1), pay(20'habcde, i[1], 2'h2),
           i[1] ? cmdv(20'h11111, 1'b1, 2'b10, 2'b01, 2'b10, 1'b1)
                : cmdv(20'h11111, 1'b1, i[1:0], 2'b11, 2'b11, 1'b1));
    look(cmdv(20'h11111, 1'b1, 2'b11, 2'b10, 2'b11, 1'b1), pay(20'habcde, 1'b0, 2'h2),
         cmdv(20'h11111, 1'b1, 2'b11, 2'b10, 2'b11, 1'b1));
    look(cmdv(20'h11111, 1'b0, 2'b11, 2'b11, 2'b11, 1'b1), pay(20'habcde, 1'b0, 2'h2),
         cmdv(20'h11111, 1'b0, 2'b11, 2'b11, 2'b11, 1'b1));
    // unplaced writes follow the internal pointer from block 0 upwards
    wr(OFS_PAYLOAD, pay(20'h55555, 1'b0, 2'h3));
    wr(OFS_COMMAND, cmdv(20'h22222, 1'b1, 2'b01, 2'b01, 2'b01, 1'b0));
    wr(OFS_PAYLOAD, pay(20'h66666, 1'b0, 2'h3));
    wr(OFS_COMMAND, cmdv(20'h2222a, 1'b1, 2'b01, 2'b01, 2'b01, 1'b0));
    look(cmdv(20'h22222, 1'b1, 2'b11, 2'b11, 2'b11, 1'b1), pay(20'h55555, 1'b1, 2'h0),
         cmdv(20'h22222, 1'b1, 2'b01, 2'b01, 2'b01, 1'b1));
    look(cmdv(20'h2222a, 1'b1, 2'b11, 2'b11, 2'b11, 1'b1), pay(20'h66666, 1'b1, 2'h1),
         cmdv(20'h2222a, 1'b1, 2'b01, 2'b01, 2'b01, 1'b1));
    // same tag placed in two blocks: a double match reads as a miss
    wr(OFS_PAYLOAD, pay(20'h77777, 1'b1, 2'h0));
    wr(OFS_COMMAND, cmdv(20'h33333, 1'b1, 2'b10, 2'b10, 2'b10, 1'b0));
    wr(OFS_PAYLOAD, pay(20'h88888, 1'b1, 2'h1));
    wr(OFS_COMMAND, cmdv(20'h33333, 1'b1, 2'b10, 2'b10, 2'b10, 1'b0));
    look(cmdv(20'h33333, 1'b1, 2'b11, 2'b11, 2'b11, 1'b1),
         pay(20'h88888, 1'b0, 2'h1),
         cmdv(20'h33333, 1'b1, 2'b11, 2'b11, 2'b11, 1'b1));
    // page directory write wipes every valid bit
    wr(OFS_PAGE_DIR, 32'hfedc_b123);
    rd(OFS_PAGE_DIR, 32'hfedc_b000);
    look(cmdv(20'h11111, 1'b1, 2'b11, 2'b11, 2'b11, 1'b1), pay(20'h88888, 1'b0, 2'h1),
         cmdv(20'h11111, 1'b1, 2'b11, 2'b11, 2'b11, 1'b1));
    // with paging on, command writes are stored but run nothing
    wr(OFS_MACHINE_CTRL, 32'hffff_ffff);
    rd(OFS_MACHINE_CTRL, 32'h8000_0000);
    wr(OFS_PAYLOAD, pay(20'h99999, 1'b1, 2'h2));
    wr(OFS_COMMAND, cmdv(20'h44444, 1'b1, 2'b10, 2'b10, 2'b10, 1'b0));
    look(cmdv(20'h44444, 1'b1, 2'b11, 2'b11, 2'b11, 1'b1), pay(20'h99999, 1'b1, 2'h2),
         cmdv(20'h44444, 1'b1, 2'b11, 2'b11, 2'b11, 1'b1));
    wr(OFS_MACHINE_CTRL, 32'h0);
    look(cmdv(20'h44444, 1'b1, 2'b11, 2'b11, 2'b11, 1'b1), pay(20'h99999, 1'b0, 2'h2),
         cmdv(20'h44444, 1'b1, 2'b11, 2'b11, 2'b11, 1'b1));
    finish_test();
  end

endmodule

`default_nettype wire
